/* File: verilog/ldo_ctl_pkg.sv */
// Constants, register map and carrier types for the regulator mode and power state control
package ldo_ctl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFS_CONV_A_CTRL = 4'h0;
  localparam logic [3:0] OFS_CONV_A_VOLT = 4'h1;
  localparam logic [3:0] OFS_REG_B_CTRL = 4'h2;
  localparam logic [3:0] OFS_REG_C_CTRL = 4'h3;
  localparam logic [3:0] OFS_REG_C_VOLT = 4'h4;
  localparam logic [3:0] OFS_LIMIT_CTRL = 4'h5;
  localparam logic [3:0] OFS_THRESH = 4'h6;
  localparam logic [3:0] OFS_STATE_CTRL = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_REG_B_LIMIT = 4'h9;
  localparam logic [3:0] OFS_REG_C_LIMIT = 4'ha;
  // Converter A control: mode in [2:0]
  localparam int MODE_LSB = 0;
  localparam logic [2:0] MODE_PARALLEL_C = 3'h5;
  // Regulator control: gain [3:0], startup level [5:4], force [6], auto disable / standalone [7]
  localparam int GAIN_LSB = 0;
  localparam int LEVEL_LSB = 4;
  localparam int FORCE_BIT = 6;
  localparam int FLAG7_BIT = 7;
  // Limit control: spacing B [3:0], spacing C [7:4]
  localparam int SPB_LSB = 0;
  localparam int SPC_LSB = 4;
  // Threshold: pair B [3:0], pair A/C [7:4]
  localparam int THB_LSB = 0;
  localparam int THAC_LSB = 4;
  // State control: coarse enables [2:0], coarse pass [3], state [5:4]
  localparam int CEN_LSB = 0;
  localparam int CPASS_BIT = 3;
  localparam int STATE_LSB = 4;
  localparam logic [1:0] ST_ACTIVE = 2'h0;
  localparam logic [1:0] ST_LOW = 2'h1;
  localparam logic [1:0] ST_SHUTOFF = 2'h2;
  localparam logic [2:0] RUN_BIAS = 3'h7;
  localparam logic [2:0] SLEEP_BIAS = 3'h1;
  localparam logic [2:0] GAIN_BASE = 3'h0;
  localparam logic [7:0] RST_CONV_A_CTRL = 8'h00;
  localparam logic [7:0] RST_VOLT = 8'h00;
  localparam logic [7:0] RST_REG_CTRL = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h88;
  localparam logic [7:0] RST_STATE = 8'h00;

  typedef enum logic [2:0] {
    PS_ACTIVE = 3'b001,
    PS_LOW = 3'b010,
    PS_SHUTOFF = 3'b100
  } power_state_e;

  typedef struct packed {
    logic flag7;
    logic force_pass;
    logic [1:0] level;
    logic [3:0] gain;
  } reg_ctrl_s;

  typedef struct packed {
    logic enable;
    logic [3:0] current;
    logic [3:0] spacing;
    logic passthrough;
  } reg_drive_s;
endpackage : ldo_ctl_pkg

/* File: verilog/ldo_limit_calc.sv */
// Pulse-spacing limited current for one regulator
`timescale 1ns/1ns
`default_nettype none
module ldo_limit_calc (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] current_max,
  input wire logic [3:0] spacing,
  output logic [7:0] limit_out
);
  logic [4:0] divisor;
  logic [7:0] scaled;
  assign divisor = {spacing, 1'b1};
  assign scaled = {current_max, 4'h0} / {3'h0, divisor};
  // Output current over twice the spacing plus one, in 1/16 units
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      limit_out <= 8'h00;
    end else begin
      limit_out <= scaled; // RULE9
    end
  end
endmodule // ldo_limit_calc
`default_nettype wire

/* File: verilog/ldo_mode_ctl.sv */
// Regulator mode selection, pass-through, coarse regulators and power state control
//Function
// RULE1: Mode 5 puts regulator C parallel to A
// RULE2: Standalone C needs enable and mode not 5
// RULE3: C target follows mode's voltage register
// RULE4: Parallel mode hands over to C near dropout
// RULE5: Output current follows gain field after startup
// RULE6: Startup level governs current before regulation
// RULE7: Software sets startup level from target voltage
// RULE8: Pulse spacing fields set minimum pulse interval
// RULE9: Limited current is max over 2n plus 1
// RULE10: Software clears limit once output is regulating
// RULE11: Software may limit before enabling regulator
// RULE12: Dropout thresholds programmable per converter pair
// RULE13: Automatic pass-through on low supply by default
// RULE14: Regulator B disable bit stops both auto passes
// RULE15: Force bit puts regulator in pass-through
// RULE16: Each coarse regulator has own enable bit
// RULE17: Coarse pass ties enabled outputs to supply
// RULE18: Low-voltage B variant lacks coarse B entirely
// RULE19: Three states; bias seven active, one low
// RULE20: Shutoff disables regulators, ADC, charge counting
// RULE21: Reset leaves device in active state
// RULE22: Force pass-through beats regulation and auto
`timescale 1ns/1ns
`default_nettype none
module ldo_mode_ctl #(
  parameter bit B_LOW_VARIANT = 1'b0
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic B_AT_TARGET,
  input wire logic C_AT_TARGET,
  input wire logic B_LOW_HEADROOM,
  input wire logic C_LOW_HEADROOM,
  input wire logic A_DROPOUT,
  output logic C_PARALLEL,
  output logic C_STANDALONE,
  output logic [7:0] C_TARGET,
  output logic A_HANDOVER,
  output logic [3:0] B_THRESH,
  output logic [3:0] AC_THRESH,
  output logic B_ENABLE,
  output logic [3:0] B_CURRENT,
  output logic [3:0] B_SPACING,
  output logic [7:0] B_LIMIT,
  output logic B_PASS,
  output logic C_ENABLE,
  output logic [3:0] C_CURRENT,
  output logic [3:0] C_SPACING,
  output logic [7:0] C_LIMIT,
  output logic C_PASS,
  output logic [2:0] COARSE_EN,
  output logic [2:0] COARSE_PASS,
  output logic [2:0] BIAS_SETTING,
  output logic ADC_ENABLE,
  output logic COUNT_ENABLE,
  output logic [2:0] POWER_STATE
);
  logic [7:0] conv_a_ctrl_r;
  logic [7:0] conv_a_volt_r;
  logic [7:0] reg_c_volt_r;
  logic [7:0] limit_r;
  logic [7:0] thresh_r;
  logic [7:0] state_ctrl_r;
  ldo_ctl_pkg::reg_ctrl_s reg_b_r;
  ldo_ctl_pkg::reg_ctrl_s reg_c_r;
  ldo_ctl_pkg::power_state_e state_r;
  ldo_ctl_pkg::power_state_e state_nxt;
  logic [1:0] b_tgt_s1_r;
  logic [1:0] b_tgt_s2_r;
  logic [2:0] hr_s1_r;
  logic [2:0] hr_s2_r;
  logic parallel_c;
  logic standalone_c;
  logic shutoff;
  logic b_pass_nxt;
  logic c_pass_nxt;
  logic [3:0] b_cur_nxt;
  logic [3:0] c_cur_nxt;
  logic [2:0] coarse_en_nxt;
  logic [7:0] b_limit;
  logic [7:0] c_limit;
  logic [7:0] rdata_nxt;
  ldo_ctl_pkg::reg_drive_s drive_b;
  ldo_ctl_pkg::reg_drive_s drive_c;

  // Register writes, one process per register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      conv_a_ctrl_r <= ldo_ctl_pkg::RST_CONV_A_CTRL;
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_CONV_A_CTRL) begin
      conv_a_ctrl_r <= WDATA; // RULE1
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      conv_a_volt_r <= ldo_ctl_pkg::RST_VOLT;
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_CONV_A_VOLT) begin
      conv_a_volt_r <= WDATA; // RULE3
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      reg_b_r <= ldo_ctl_pkg::reg_ctrl_s'(ldo_ctl_pkg::RST_REG_CTRL);
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_REG_B_CTRL) begin
      reg_b_r <= ldo_ctl_pkg::reg_ctrl_s'(WDATA); // RULE14
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      reg_c_r <= ldo_ctl_pkg::reg_ctrl_s'(ldo_ctl_pkg::RST_REG_CTRL);
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_REG_C_CTRL) begin
      reg_c_r <= ldo_ctl_pkg::reg_ctrl_s'(WDATA); // RULE2
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      reg_c_volt_r <= ldo_ctl_pkg::RST_VOLT;
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_REG_C_VOLT) begin
      reg_c_volt_r <= WDATA; // RULE3
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      limit_r <= ldo_ctl_pkg::RST_LIMIT;
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_LIMIT_CTRL) begin
      limit_r <= WDATA; // RULE8
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      thresh_r <= ldo_ctl_pkg::RST_THRESH;
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_THRESH) begin
      thresh_r <= WDATA; // RULE12
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ctrl_r <= ldo_ctl_pkg::RST_STATE;
    end else if (WR && ADDR == ldo_ctl_pkg::OFS_STATE_CTRL) begin
      state_ctrl_r <= WDATA; // RULE19
    end
  end

  // Synchronisers for analog status levels
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      b_tgt_s1_r <= 2'h0;
      b_tgt_s2_r <= 2'h0;
      hr_s1_r <= 3'h0;
      hr_s2_r <= 3'h0;
    end else begin
      b_tgt_s1_r <= {C_AT_TARGET, B_AT_TARGET};
      b_tgt_s2_r <= b_tgt_s1_r;
      hr_s1_r <= {A_DROPOUT, C_LOW_HEADROOM, B_LOW_HEADROOM};
      hr_s2_r <= hr_s1_r;
    end
  end

  // Power state from the state field
  always_comb begin
    case (state_ctrl_r[ldo_ctl_pkg::STATE_LSB +: 2])
      ldo_ctl_pkg::ST_ACTIVE: state_nxt = ldo_ctl_pkg::PS_ACTIVE;
      ldo_ctl_pkg::ST_LOW: state_nxt = ldo_ctl_pkg::PS_LOW;
      ldo_ctl_pkg::ST_SHUTOFF: state_nxt = ldo_ctl_pkg::PS_SHUTOFF;
      default: state_nxt = state_r;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ldo_ctl_pkg::PS_ACTIVE; // RULE21
    end else begin
      state_r <= state_nxt; // RULE19
    end
  end

  assign shutoff = (state_r == ldo_ctl_pkg::PS_SHUTOFF);
  assign parallel_c = (conv_a_ctrl_r[ldo_ctl_pkg::MODE_LSB +: 3] ==
    ldo_ctl_pkg::MODE_PARALLEL_C); // RULE1
  assign standalone_c = reg_c_r.flag7 && !parallel_c; // RULE2

  // Force beats auto; auto gated by the single disable bit in regulator B control
  assign b_pass_nxt = reg_b_r.force_pass ||
    (!reg_b_r.flag7 && hr_s2_r[0]); // RULE13 RULE14 RULE15 RULE22
  assign c_pass_nxt = reg_c_r.force_pass ||
    (!reg_b_r.flag7 && hr_s2_r[1]); // RULE13 RULE14 RULE15 RULE22

  // Startup level until target reached, then gain
  assign b_cur_nxt = b_tgt_s2_r[0] ? reg_b_r.gain :
    {2'h0, reg_b_r.level}; // RULE5 RULE6
  assign c_cur_nxt = b_tgt_s2_r[1] ? reg_c_r.gain :
    {2'h0, reg_c_r.level}; // RULE5 RULE6

  // Coarse enables, with output B removed on the low-voltage variant
  assign coarse_en_nxt = state_ctrl_r[ldo_ctl_pkg::CEN_LSB +: 3] &
    {1'b1, !B_LOW_VARIANT, 1'b1}; // RULE16 RULE18

  ldo_limit_calc u_limit_b (
    .CLK(CLK),
    .RESETN(RESETN),
    .current_max(b_cur_nxt),
    .spacing(limit_r[ldo_ctl_pkg::SPB_LSB +: 4]),
    .limit_out(b_limit)
  );

  ldo_limit_calc u_limit_c (
    .CLK(CLK),
    .RESETN(RESETN),
    .current_max(c_cur_nxt),
    .spacing(limit_r[ldo_ctl_pkg::SPC_LSB +: 4]),
    .limit_out(c_limit)
  );

  // Per-regulator drive bundles
  always_comb begin
    drive_b = '0;
    drive_b.enable = !shutoff; // RULE20
    drive_b.current = b_cur_nxt; // RULE5 RULE6
    drive_b.spacing = limit_r[ldo_ctl_pkg::SPB_LSB +: 4]; // RULE8
    drive_b.passthrough = b_pass_nxt && !shutoff; // RULE20
  end

  always_comb begin
    drive_c = '0;
    drive_c.enable = (parallel_c || standalone_c) && !shutoff; // RULE20
    drive_c.current = c_cur_nxt; // RULE5 RULE6
    drive_c.spacing = limit_r[ldo_ctl_pkg::SPC_LSB +: 4]; // RULE8
    drive_c.passthrough = c_pass_nxt && !shutoff; // RULE20
  end

  // Regulator C mode and converter A handover
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      C_PARALLEL <= 1'b0;
      C_STANDALONE <= 1'b0;
      C_TARGET <= 8'h00;
      A_HANDOVER <= 1'b0;
    end else begin
      C_PARALLEL <= parallel_c && !shutoff; // RULE1 RULE20
      C_STANDALONE <= standalone_c && !shutoff; // RULE2 RULE20
      C_TARGET <= parallel_c ? conv_a_volt_r : reg_c_volt_r; // RULE3
      A_HANDOVER <= parallel_c && !shutoff && hr_s2_r[2]; // RULE4
    end
  end

  // Regulator B drive
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      B_ENABLE <= 1'b0;
      B_CURRENT <= 4'h0;
      B_SPACING <= 4'h0;
      B_PASS <= 1'b0;
      B_LIMIT <= 8'h00;
    end else begin
      B_ENABLE <= drive_b.enable; // RULE20
      B_CURRENT <= drive_b.current; // RULE5
      B_SPACING <= drive_b.spacing; // RULE8
      B_PASS <= drive_b.passthrough; // RULE13 RULE15
      B_LIMIT <= b_limit; // RULE9
    end
  end

  // Regulator C drive
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      C_ENABLE <= 1'b0;
      C_CURRENT <= 4'h0;
      C_SPACING <= 4'h0;
      C_PASS <= 1'b0;
      C_LIMIT <= 8'h00;
    end else begin
      C_ENABLE <= drive_c.enable; // RULE20
      C_CURRENT <= drive_c.current; // RULE5
      C_SPACING <= drive_c.spacing; // RULE8
      C_PASS <= drive_c.passthrough; // RULE13 RULE15
      C_LIMIT <= c_limit; // RULE9
    end
  end

  // Dropout thresholds
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      B_THRESH <= 4'h0;
      AC_THRESH <= 4'h0;
    end else begin
      B_THRESH <= thresh_r[ldo_ctl_pkg::THB_LSB +: 4]; // RULE12
      AC_THRESH <= thresh_r[ldo_ctl_pkg::THAC_LSB +: 4]; // RULE12
    end
  end

  // Coarse regulators and state-dependent services
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      COARSE_EN <= 3'h0;
      COARSE_PASS <= 3'h0;
      BIAS_SETTING <= ldo_ctl_pkg::RUN_BIAS;
      ADC_ENABLE <= 1'b1;
      COUNT_ENABLE <= 1'b1;
      POWER_STATE <= 3'b001;
    end else begin
      COARSE_EN <= shutoff ? coarse_en_nxt : 3'h0; // RULE16 RULE19 RULE20
      COARSE_PASS <= (shutoff && state_ctrl_r[ldo_ctl_pkg::CPASS_BIT]) ?
        coarse_en_nxt : 3'h0; // RULE17 RULE18
      case (state_r)
        ldo_ctl_pkg::PS_ACTIVE: BIAS_SETTING <= ldo_ctl_pkg::RUN_BIAS; // RULE19
        ldo_ctl_pkg::PS_LOW: BIAS_SETTING <= ldo_ctl_pkg::SLEEP_BIAS; // RULE19
        default: BIAS_SETTING <= ldo_ctl_pkg::GAIN_BASE;
      endcase
      ADC_ENABLE <= !shutoff; // RULE20
      COUNT_ENABLE <= !shutoff; // RULE20
      POWER_STATE <= state_r;
    end
  end

  // Register read mux
  always_comb begin
    case (ADDR)
      ldo_ctl_pkg::OFS_CONV_A_CTRL: rdata_nxt = conv_a_ctrl_r;
      ldo_ctl_pkg::OFS_CONV_A_VOLT: rdata_nxt = conv_a_volt_r;
      ldo_ctl_pkg::OFS_REG_B_CTRL: rdata_nxt = reg_b_r;
      ldo_ctl_pkg::OFS_REG_C_CTRL: rdata_nxt = reg_c_r;
      ldo_ctl_pkg::OFS_REG_C_VOLT: rdata_nxt = reg_c_volt_r;
      ldo_ctl_pkg::OFS_LIMIT_CTRL: rdata_nxt = limit_r;
      ldo_ctl_pkg::OFS_THRESH: rdata_nxt = thresh_r;
      ldo_ctl_pkg::OFS_STATE_CTRL: rdata_nxt = state_ctrl_r;
      ldo_ctl_pkg::OFS_STATUS: rdata_nxt = {B_PASS, C_PASS, 1'b0, state_r,
        b_tgt_s2_r[1], b_tgt_s2_r[0]}; // RULE10
      ldo_ctl_pkg::OFS_REG_B_LIMIT: rdata_nxt = b_limit;
      ldo_ctl_pkg::OFS_REG_C_LIMIT: rdata_nxt = c_limit;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rdata_nxt : 8'h00;
    end
  end
endmodule // ldo_mode_ctl
`default_nettype wire

/* File: verif/ldo_mode_ctl_monitor.sv */
// Checker for the regulator mode and power state control ports
`timescale 1ns/1ns
`default_nettype none
module ldo_mode_ctl_monitor #(
  parameter bit B_LOW_VARIANT = 1'b0
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic C_PARALLEL,
  input wire logic C_STANDALONE,
  input wire logic A_HANDOVER,
  input wire logic [3:0] B_CURRENT,
  input wire logic [3:0] B_SPACING,
  input wire logic [7:0] B_LIMIT,
  input wire logic B_PASS,
  input wire logic C_PASS,
  input wire logic [2:0] COARSE_EN,
  input wire logic [2:0] COARSE_PASS,
  input wire logic [2:0] BIAS_SETTING,
  input wire logic ADC_ENABLE,
  input wire logic COUNT_ENABLE,
  input wire logic [2:0] POWER_STATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [7:0] b_exp;
  assign b_exp = 8'({B_CURRENT, 4'h0} / ({1'b0, B_SPACING, 1'b0} + 6'h01));
  a_state_onehot: assert property ($onehot(POWER_STATE)) else $error("state not one-hot");
  a_bias_active: assert property (POWER_STATE == 3'h1 && $past(POWER_STATE) == 3'h1
    |-> BIAS_SETTING == 3'h7) else $error("active bias wrong");
  a_bias_low: assert property (POWER_STATE == 3'h2 && $past(POWER_STATE) == 3'h2
    |-> BIAS_SETTING == 3'h1) else $error("low bias wrong");
  a_shutoff_quiet: assert property (POWER_STATE == 3'h4 && $past(POWER_STATE) == 3'h4
    |-> !ADC_ENABLE && !COUNT_ENABLE && !B_PASS && !C_PASS) else $error("shutoff not quiet");
  a_coarse_gate: assert property (POWER_STATE != 3'h4 && $past(POWER_STATE) != 3'h4
    |-> COARSE_EN == 3'h0 && COARSE_PASS == 3'h0) else $error("coarse on outside shutoff");
  a_force_b: assert property (WR && ADDR == 4'h2 && WDATA[6] && POWER_STATE == 3'h1
    |-> ##[1:3] B_PASS) else $error("force pass ignored");
  a_mode_parallel: assert property (WR && ADDR == 4'h0 && WDATA[2:0] == 3'h5
    && POWER_STATE == 3'h1 |-> ##[1:3] C_PARALLEL) else $error("parallel mode missing");
  a_mode_exclusive: assert property (C_PARALLEL && $past(C_PARALLEL, 2)
    |-> !C_STANDALONE) else $error("standalone while parallel");
  a_handover_mode: assert property (A_HANDOVER |-> C_PARALLEL || $past(C_PARALLEL))
    else $error("handover outside parallel");
  a_limit_b: assert property (($stable(B_CURRENT) && $stable(B_SPACING)) [*4]
    |-> B_LIMIT == b_exp) else $error("limit wrong");
  a_variant_b: assert property (B_LOW_VARIANT |-> !COARSE_EN[1] && !COARSE_PASS[1])
    else $error("coarse B on variant");
  c_handover: cover property (C_PARALLEL && A_HANDOVER);
  c_coarse_pass: cover property (POWER_STATE == 3'h4 && COARSE_PASS != 3'h0);
  c_both_pass: cover property (B_PASS && C_PASS);
endmodule // ldo_mode_ctl_monitor
`default_nettype wire

/* File: verif/ldo_analog_model.sv */
// Behavioural model of the regulator pass devices and supply sensing
`timescale 1ns/1ns
`default_nettype none
module ldo_analog_model (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic tgt_req,
  input wire logic low_req,
  input wire logic near_req,
  input wire logic [3:0] settle,
  output logic B_AT_TARGET,
  output logic C_AT_TARGET,
  output logic B_LOW_HEADROOM,
  output logic C_LOW_HEADROOM,
  output logic A_DROPOUT
);
  logic [3:0] wait_r;
  // Outputs reach target only after the settle time
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wait_r <= 4'h0;
    end else if (!tgt_req) begin
      wait_r <= 4'h0;
    end else if (wait_r != settle) begin
      wait_r <= wait_r + 4'h1;
    end
  end
  assign B_AT_TARGET = tgt_req && wait_r == settle;
  assign C_AT_TARGET = B_AT_TARGET;
  // Supply sensing follows the bench's supply level
  assign B_LOW_HEADROOM = low_req;
  assign C_LOW_HEADROOM = low_req;
  assign A_DROPOUT = near_req;
endmodule // ldo_analog_model
`default_nettype wire

/* File: verif/ldo_mode_ctl_tb.sv */
// Self-checking bench for the regulator mode and power state control
`timescale 1ns/1ns
`default_nettype none
module ldo_mode_ctl_tb;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
    logic [3:0] sel;
    logic [7:0] exp;
  } row_s;
  logic clk, resetn, wr_stb, rd_stb, tgt, low, near, c_par, c_sa, handover, b_en, c_en;
  logic b_pass, c_pass, adc_en, cnt_en, b_at, c_at, b_low, c_low, a_drop;
  logic [3:0] addr, b_thresh, ac_thresh, b_current, b_spacing, c_current, c_spacing;
  logic [7:0] wdata, rdata, c_target, b_limit, c_limit, v;
  logic [2:0] coarse_en, coarse_pass, bias, pstate, v_coarse;
  int error_cnt, check_count;
  row_s rows [20] = '{
    '{4'h1, 8'h3c, 4'h2, 8'h00}, '{4'h4, 8'ha5, 4'h2, 8'ha5},
    '{4'h3, 8'ha9, 4'h1, 8'h01}, '{4'h0, 8'h05, 4'h0, 8'h01},
    '{4'h0, 8'h05, 4'h1, 8'h00}, '{4'h0, 8'h05, 4'h2, 8'h3c},
    '{4'h6, 8'h5a, 4'h3, 8'h0a}, '{4'h6, 8'h5a, 4'h4, 8'h05},
    '{4'h5, 8'h31, 4'h5, 8'h01}, '{4'h5, 8'h31, 4'h6, 8'h03},
    '{4'h3, 8'ha9, 4'h8, 8'h02}, '{4'h2, 8'h37, 4'h7, 8'h03},
    '{4'h7, 8'h10, 4'h9, 8'h01}, '{4'h7, 8'h10, 4'ha, 8'h02},
    '{4'h7, 8'h2f, 4'hb, 8'h07}, '{4'h7, 8'h2f, 4'hc, 8'h07},
    '{4'h7, 8'h2f, 4'hd, 8'h05}, '{4'h7, 8'h2f, 4'h9, 8'h00},
    '{4'h7, 8'h00, 4'hb, 8'h00}, '{4'h7, 8'h00, 4'h9, 8'h07}};
  ldo_mode_ctl dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .B_AT_TARGET(b_at), .C_AT_TARGET(c_at), .B_LOW_HEADROOM(b_low),
    .C_LOW_HEADROOM(c_low), .A_DROPOUT(a_drop), .C_PARALLEL(c_par), .C_STANDALONE(c_sa),
    .C_TARGET(c_target), .A_HANDOVER(handover), .B_THRESH(b_thresh), .AC_THRESH(ac_thresh),
    .B_ENABLE(b_en), .B_CURRENT(b_current), .B_SPACING(b_spacing), .B_LIMIT(b_limit),
    .B_PASS(b_pass), .C_ENABLE(c_en), .C_CURRENT(c_current), .C_SPACING(c_spacing),
    .C_LIMIT(c_limit), .C_PASS(c_pass), .COARSE_EN(coarse_en), .COARSE_PASS(coarse_pass),
    .BIAS_SETTING(bias), .ADC_ENABLE(adc_en), .COUNT_ENABLE(cnt_en), .POWER_STATE(pstate));
  ldo_mode_ctl #(.B_LOW_VARIANT(1'b1)) dut_v (.CLK(clk), .RESETN(resetn), .ADDR(addr),
    .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(), .B_AT_TARGET(b_at), .C_AT_TARGET(c_at),
    .B_LOW_HEADROOM(b_low), .C_LOW_HEADROOM(c_low), .A_DROPOUT(a_drop), .C_PARALLEL(),
    .C_STANDALONE(), .C_TARGET(), .A_HANDOVER(), .B_THRESH(), .AC_THRESH(), .B_ENABLE(),
    .B_CURRENT(), .B_SPACING(), .B_LIMIT(), .B_PASS(), .C_ENABLE(), .C_CURRENT(), .C_SPACING(),
    .C_LIMIT(), .C_PASS(), .COARSE_EN(v_coarse), .COARSE_PASS(), .BIAS_SETTING(),
    .ADC_ENABLE(), .COUNT_ENABLE(), .POWER_STATE());
  ldo_analog_model model (.CLK(clk), .RESETN(resetn), .tgt_req(tgt), .low_req(low),
    .near_req(near), .settle(4'h2), .B_AT_TARGET(b_at), .C_AT_TARGET(c_at),
    .B_LOW_HEADROOM(b_low), .C_LOW_HEADROOM(c_low), .A_DROPOUT(a_drop));
  function automatic logic [7:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return 8'(c_par);
      4'h1: return 8'(c_sa);
      4'h2: return c_target;
      4'h3: return 8'(b_thresh);
      4'h4: return 8'(ac_thresh);
      4'h5: return 8'(b_spacing);
      4'h6: return 8'(c_spacing);
      4'h7: return 8'(b_current);
      4'h8: return 8'(c_current);
      4'h9: return 8'(bias);
      4'ha: return 8'(pstate);
      4'hb: return 8'(coarse_en);
      4'hc: return 8'(coarse_pass);
      default: return 8'(v_coarse);
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {resetn, wr_stb, rd_stb, tgt, low, near, addr, wdata} = '0;
    tick(20);
    chk(8'({pstate, bias, adc_en, cnt_en}), 8'h3f);
    @(posedge clk);
    resetn <= 1'b1;
    rd(4'h6, v);
    chk(v, 8'h88);
    wr(4'hf, 8'hff);
    rd(4'hf, v);
    chk(v, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      tick(6);
      chk(pick(rows[i].sel), rows[i].exp);
    end
    tgt <= 1'b1;
    tick(12);
    chk(8'({b_current, c_current}), 8'h79);
    chk(8'({b_en, c_en}), 8'h03);
    chk(b_limit, 8'h25);
    chk(c_limit, 8'h14);
    wr(4'h5, 8'h00);
    tick(6);
    chk(b_limit, 8'h70);
    low <= 1'b1;
    near <= 1'b1;
    tick(8);
    chk(8'({b_pass, c_pass, handover}), 8'h07);
    wr(4'h2, 8'hb7);
    tick(6);
    chk(8'({b_pass, c_pass}), 8'h00);
    wr(4'h2, 8'hf7);
    wr(4'h3, 8'he9);
    tick(6);
    chk(8'({b_pass, c_pass}), 8'h03);
    rd(4'h8, v);
    chk(v, 8'hc7);
    wr(4'h0, 8'h00);
    tick(6);
    chk(8'({c_par, handover}), 8'h00);
    wr(4'h7, 8'h20);
    tick(6);
    chk(8'({b_pass, c_pass, adc_en, cnt_en, b_en, c_en}), 8'h00);
    @(posedge clk);
    resetn <= 1'b0;
    tick(2);
    chk(8'({pstate, bias, adc_en, cnt_en}), 8'h3f);
    report_and_stop;
  end
endmodule // ldo_mode_ctl_tb
bind ldo_mode_ctl ldo_mode_ctl_monitor #(.B_LOW_VARIANT(B_LOW_VARIANT)) mon (.CLK(CLK),
  .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .C_PARALLEL(C_PARALLEL),
  .C_STANDALONE(C_STANDALONE), .A_HANDOVER(A_HANDOVER), .B_CURRENT(B_CURRENT),
  .B_SPACING(B_SPACING), .B_LIMIT(B_LIMIT), .B_PASS(B_PASS), .C_PASS(C_PASS),
  .COARSE_EN(COARSE_EN), .COARSE_PASS(COARSE_PASS), .BIAS_SETTING(BIAS_SETTING),
  .ADC_ENABLE(ADC_ENABLE), .COUNT_ENABLE(COUNT_ENABLE), .POWER_STATE(POWER_STATE));
`default_nettype wire
